// ===== hw/dcf_fifo.sv
// 16 x 4 strobe-driven fifo with register port and interrupt
//
// Behaviour
// - The buffer holds up to sixteen four-bit words in arrival order.
// - A rising load strobe stores the input word unless the buffer is full.
// - A rising unload strobe drops the oldest word unless the buffer is empty.
// - The buffer is full when loads exceed unloads by sixteen.
// - Load edges while full change neither contents nor write pointer.
// - Unload edges while empty change neither contents nor read pointer.
// - Input ready is high during clear, otherwise only when not full and the load strobe is low.
// - Output ready is high only when not empty and the unload strobe is high.
// - Clear low resets both pointers, forces input ready high, output low.
// - Words leave the data outputs with the polarity they were written.
// - Data outputs are released whenever the drive enable is low.
// - The drive enable never affects the two ready flags.
// - The output word is invalid whenever the stored count is zero.
// - Loads and unloads run at unrelated rates up to 10 MHz each.
`timescale 1ns/1ns
module dcf_fifo (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // producer pins
  input wire logic load_strobe,
  input wire logic [dcf_pkg::WIDTH-1:0] data_in,
  output logic input_ready_flag,
  // consumer pins
  input wire logic unload_strobe,
  input wire logic output_drive_en,
  output logic [dcf_pkg::WIDTH-1:0] data_out,
  output logic data_out_oe,
  output logic output_ready_flag,
  // stack clear, active low
  input wire logic stack_clear_n,
  // register port
  input wire logic [dcf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dcf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dcf_pkg::DATA_W-1:0] reg_rdata,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    // storage and pointers
    logic [dcf_pkg::DEPTH-1:0][dcf_pkg::WIDTH-1:0] mem;
    logic [dcf_pkg::PTR_W-1:0] wr_ptr;
    logic [dcf_pkg::PTR_W-1:0] rd_ptr;
    // strobe history and one-cycle control
    logic load_prev;
    logic unload_prev;
    logic soft_clear;
    // registered pin outputs
    logic [dcf_pkg::WIDTH-1:0] dout;
    logic dout_oe;
    logic in_ready;
    logic out_ready;
    // register side
    logic [dcf_pkg::EV_W-1:0] irq_stat;
    logic [dcf_pkg::EV_W-1:0] irq_mask;
    logic [dcf_pkg::DATA_W-1:0] rdata;
    logic irq;
  } dcf_state_t;

  localparam dcf_state_t STATE_RST = '{
    mem: '0,
    wr_ptr: '0,
    rd_ptr: '0,
    load_prev: 1'b0,
    unload_prev: 1'b0,
    soft_clear: 1'b0,
    dout: '0,
    dout_oe: 1'b0,
    in_ready: 1'b1,
    out_ready: 1'b0,
    irq_stat: '0,
    irq_mask: dcf_pkg::IRQ_MASK_RST,
    rdata: '0,
    irq: 1'b0
  };

  dcf_state_t s;
  dcf_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // pointers carry one wrap bit so sixteen stored words differ from none
  function automatic logic [dcf_pkg::CNT_W-1:0] ptr_count(
    input logic [dcf_pkg::PTR_W-1:0] wp,
    input logic [dcf_pkg::PTR_W-1:0] rp
  );
    ptr_count = wp - rp;
  endfunction : ptr_count

  function automatic logic [dcf_pkg::PTR_W-1:0] ptr_step(
    input logic [dcf_pkg::PTR_W-1:0] p
  );
    ptr_step = p + 5'h01;
  endfunction : ptr_step

  // low pointer bits pick the cell; the top bit only tells laps apart
  function automatic logic [3:0] ptr_cell(
    input logic [dcf_pkg::PTR_W-1:0] p
  );
    ptr_cell = p[3:0];
  endfunction : ptr_cell

  function automatic logic cnt_is_full(
    input logic [dcf_pkg::CNT_W-1:0] c
  );
    cnt_is_full = (c == dcf_pkg::CNT_FULL);
  endfunction : cnt_is_full

  function automatic logic cnt_is_empty(
    input logic [dcf_pkg::CNT_W-1:0] c
  );
    cnt_is_empty = (c == dcf_pkg::CNT_EMPTY);
  endfunction : cnt_is_empty

  // level high now that was low at the previous sample
  function automatic logic went_high(
    input logic lvl,
    input logic prev
  );
    went_high = lvl & ~prev;
  endfunction : went_high

  // status view: count, full, empty, both flags, clearing, drive enable
  function automatic logic [dcf_pkg::DATA_W-1:0] status_pack(
    input logic [dcf_pkg::CNT_W-1:0] c,
    input logic in_rdy,
    input logic out_rdy,
    input logic clr,
    input logic drv
  );
    status_pack = '0;
    status_pack[dcf_pkg::ST_COUNT_LSB +: dcf_pkg::CNT_W] = c;
    status_pack[dcf_pkg::ST_FULL] = cnt_is_full(c);
    status_pack[dcf_pkg::ST_EMPTY] = cnt_is_empty(c);
    status_pack[dcf_pkg::ST_IN_READY] = in_rdy;
    status_pack[dcf_pkg::ST_OUT_READY] = out_rdy;
    status_pack[dcf_pkg::ST_CLEARING] = clr;
    status_pack[dcf_pkg::ST_DRIVE_EN] = drv;
  endfunction : status_pack

  // read mux; control and unmapped offsets read as zero
  function automatic logic [dcf_pkg::DATA_W-1:0] reg_view(
    input logic [dcf_pkg::ADDR_W-1:0] a,
    input logic [dcf_pkg::DATA_W-1:0] status,
    input logic [dcf_pkg::EV_W-1:0] stat,
    input logic [dcf_pkg::EV_W-1:0] mask
  );
    reg_view = '0;
    case (a)
      dcf_pkg::OFS_STATUS: begin
        reg_view = status;
      end
      dcf_pkg::OFS_IRQ_STAT: begin
        reg_view[dcf_pkg::EV_W-1:0] = stat;
      end
      dcf_pkg::OFS_IRQ_MASK: begin
        reg_view[dcf_pkg::EV_W-1:0] = mask;
      end
      default: begin
        reg_view = '0;
      end
    endcase
  endfunction : reg_view

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [dcf_pkg::PIN_W-1:0] pins_raw;
  logic [dcf_pkg::PIN_W-1:0] pins;

  // data rides the same two stages as its strobe, so a word set up
  // before the strobe rises is the word seen at the detected edge
  assign pins_raw = {data_in, output_drive_en, stack_clear_n,
                     unload_strobe, load_strobe};

  // clear_n resets to low, so the stack stays cleared until the pin is seen
  dcf_sync #(
    .W(dcf_pkg::PIN_W),
    .RST_VAL(dcf_pkg::PIN_RST)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(pins_raw),
    .q(pins)
  );

  logic load_lvl;
  logic unload_lvl;
  logic clear_n_lvl;
  logic drive_en_lvl;
  logic [dcf_pkg::WIDTH-1:0] din_lvl;

  assign load_lvl = pins[dcf_pkg::PIN_LOAD];
  assign unload_lvl = pins[dcf_pkg::PIN_UNLOAD];
  assign clear_n_lvl = pins[dcf_pkg::PIN_CLEAR_N];
  assign drive_en_lvl = pins[dcf_pkg::PIN_DRIVE_EN];
  assign din_lvl = pins[dcf_pkg::PIN_DATA_LSB +: dcf_pkg::WIDTH];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic clearing;
  logic load_rise;
  logic unload_rise;
  logic [dcf_pkg::CNT_W-1:0] cnt_now;
  logic [dcf_pkg::CNT_W-1:0] cnt_next;
  logic full_now;
  logic empty_now;
  logic [dcf_pkg::EV_W-1:0] events;
  logic [dcf_pkg::DATA_W-1:0] status_word;

  always_comb begin
    next_s = s;
    events = '0;
    status_word = '0;

    // pin and control write clear alike
    clearing = ~clear_n_lvl | s.soft_clear;
    // strobe edges found on the system clock, 10 MHz sample rate
    load_rise = went_high(load_lvl, s.load_prev);
    unload_rise = went_high(unload_lvl, s.unload_prev);
    cnt_now = ptr_count(s.wr_ptr, s.rd_ptr);
    full_now = cnt_is_full(cnt_now);
    empty_now = cnt_is_empty(cnt_now);

    next_s.load_prev = load_lvl;
    next_s.unload_prev = unload_lvl;
    next_s.soft_clear = 1'b0;

    if (clearing) begin
      // edges during clear are dropped; contents stay but are unreachable
      next_s.wr_ptr = '0;
      next_s.rd_ptr = '0;
      // one event per cycle of clear, whichever source holds it
      events[dcf_pkg::EV_CLEAR] = 1'b1;
    end else begin
      if (load_rise) begin
        if (!full_now) begin
          next_s.mem[ptr_cell(s.wr_ptr)] = din_lvl;
          next_s.wr_ptr = ptr_step(s.wr_ptr);
          events[dcf_pkg::EV_LOAD] = 1'b1;
        end else begin
          // full: memory and write pointer untouched
          events[dcf_pkg::EV_OVERFLOW] = 1'b1;
        end
      end
      if (unload_rise) begin
        if (!empty_now) begin
          next_s.rd_ptr = ptr_step(s.rd_ptr);
          events[dcf_pkg::EV_UNLOAD] = 1'b1;
        end else begin
          events[dcf_pkg::EV_UNDERFLOW] = 1'b1;
        end
      end
    end

    cnt_next = ptr_count(next_s.wr_ptr, next_s.rd_ptr);
    events[dcf_pkg::EV_FULL] = cnt_is_full(cnt_next) & ~full_now;

    // oldest word, passed straight through with no inversion
    next_s.dout = next_s.mem[ptr_cell(next_s.rd_ptr)];
    next_s.dout_oe = drive_en_lvl;

    // flags ignore the drive enable entirely
    // a wider word needs these flags ANDed across a rank outside
    next_s.in_ready = clearing |
      (~cnt_is_full(cnt_next) & ~load_lvl);
    next_s.out_ready = ~clearing &
      ~cnt_is_empty(cnt_next) & unload_lvl;

    // status view for the register port
    status_word = status_pack(cnt_now, s.in_ready, s.out_ready, clearing,
      s.dout_oe);

    // register writes; a new event beats a write-one clear
    next_s.irq_stat = s.irq_stat;
    if (reg_wr) begin
      case (reg_addr)
        dcf_pkg::OFS_CTRL: begin
          next_s.soft_clear = reg_wdata[dcf_pkg::CTRL_SOFT_CLEAR];
        end
        dcf_pkg::OFS_IRQ_STAT: begin
          next_s.irq_stat = s.irq_stat & ~reg_wdata[dcf_pkg::EV_W-1:0];
        end
        dcf_pkg::OFS_IRQ_MASK: begin
          next_s.irq_mask = reg_wdata[dcf_pkg::EV_W-1:0];
        end
        default: begin
          next_s.soft_clear = 1'b0;
        end
      endcase
    end
    next_s.irq_stat = next_s.irq_stat | events;

    // read data stands only in the cycle after the read strobe
    next_s.rdata = '0;
    if (reg_rd) begin
      next_s.rdata = reg_view(reg_addr, status_word, s.irq_stat,
        s.irq_mask);
    end

    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign data_out = s.dout;
  assign data_out_oe = s.dout_oe;
  assign input_ready_flag = s.in_ready;
  assign output_ready_flag = s.out_ready;
  assign reg_rdata = s.rdata;
  assign irq = s.irq;

endmodule : dcf_fifo

// ===== common/dcf_pkg.sv
// constants shared by the dual clock fifo block
package dcf_pkg;

  // storage shape
  localparam int DEPTH = 16;
  localparam int WIDTH = 4;
  localparam int PTR_W = 5;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_EMPTY = 5'h00;

  // timing: system clock and the highest strobe rate per side
  localparam int CLK_PERIOD_NS = 100;
  localparam int MAX_RATE_MHZ = 10;
  localparam int SYNC_STAGES = 2;

  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;

  // control register fields
  localparam int CTRL_SOFT_CLEAR = 0;

  // status register fields
  localparam int ST_COUNT_LSB = 0;
  localparam int ST_FULL = 5;
  localparam int ST_EMPTY = 6;
  localparam int ST_IN_READY = 7;
  localparam int ST_OUT_READY = 8;
  localparam int ST_CLEARING = 9;
  localparam int ST_DRIVE_EN = 10;

  // event bits, shared by irq status and irq mask
  localparam int EV_W = 6;
  localparam int EV_LOAD = 0;
  localparam int EV_UNLOAD = 1;
  localparam int EV_OVERFLOW = 2;
  localparam int EV_UNDERFLOW = 3;
  localparam int EV_FULL = 4;
  localparam int EV_CLEAR = 5;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 6'h00;

  // synchronised pin bundle layout
  localparam int PIN_W = 8;
  localparam int PIN_LOAD = 0;
  localparam int PIN_UNLOAD = 1;
  localparam int PIN_CLEAR_N = 2;
  localparam int PIN_DRIVE_EN = 3;
  localparam int PIN_DATA_LSB = 4;
  localparam logic [PIN_W-1:0] PIN_RST = 8'h00;

endpackage : dcf_pkg

// ===== hw/dcf_sync.sv
// two-stage synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ns
module dcf_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pins in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : dcf_sync

// ===== bench/dcf_fifo_sva.sv
// pin-level assertions for the dcf fifo
`timescale 1ns/1ns
module dcf_fifo_chk (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pins
  input wire logic load_strobe,
  input wire logic unload_strobe,
  input wire logic stack_clear_n,
  input wire logic output_drive_en,
  input wire logic [dcf_pkg::WIDTH-1:0] data_out,
  input wire logic data_out_oe,
  input wire logic input_ready_flag,
  input wire logic output_ready_flag,
  // register port
  input wire logic [dcf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dcf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [dcf_pkg::DATA_W-1:0] reg_rdata,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_mask0;
    reg_wr && reg_addr == dcf_pkg::OFS_IRQ_MASK && reg_wdata[5:0] == 6'h00;
  endsequence
  // long enough that no strobe edge is still in the sync pipe
  sequence s_quiet;
    (!load_strobe && !unload_strobe && stack_clear_n && !reg_wr)[*6];
  endsequence
  property p_oe_on;
    output_drive_en[*4] |=> data_out_oe;
  endproperty
  property p_oe_off;
    !output_drive_en[*4] |=> !data_out_oe;
  endproperty
  property p_ir_load;
    (load_strobe && stack_clear_n)[*5] |=> !input_ready_flag;
  endproperty
  property p_or_unl;
    !unload_strobe[*4] |=> !output_ready_flag;
  endproperty
  property p_clear;
    !stack_clear_n[*4] |=> input_ready_flag && !output_ready_flag;
  endproperty
  property p_rdata;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  property p_irq_mask;
    s_mask0 ##1 !reg_wr |=> !irq;
  endproperty
  property p_hold;
    s_quiet |=> $stable(data_out);
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe not driven");
  a_oe_off: assert property (p_oe_off) else $error("oe not off");
  a_ir_load: assert property (p_ir_load) else $error("ir high");
  a_or_unl: assert property (p_or_unl) else $error("or high");
  a_clear: assert property (p_clear) else $error("clear flags");
  a_rdata: assert property (p_rdata) else $error("stray rdata");
  a_irq_mask: assert property (p_irq_mask) else $error("irq masked");
  a_hold: assert property (p_hold) else $error("data moved");
endmodule : dcf_fifo_chk

bind dcf_fifo dcf_fifo_chk dcf_fifo_chk_inst (
  .clk(clk), .sys_rst(sys_rst), .load_strobe(load_strobe),
  .unload_strobe(unload_strobe), .stack_clear_n(stack_clear_n),
  .output_drive_en(output_drive_en), .data_out(data_out),
  .data_out_oe(data_out_oe), .input_ready_flag(input_ready_flag),
  .output_ready_flag(output_ready_flag), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq)
);

// ===== bench/dcf_peer.sv
// producer and consumer model driving the fifo strobes
`timescale 1ns/1ns
module dcf_peer (
  // producer side
  output logic load_strobe,
  output logic [dcf_pkg::WIDTH-1:0] data_in,
  input wire logic input_ready_flag,
  // consumer side
  output logic unload_strobe,
  input wire logic output_ready_flag
);
  initial begin
    load_strobe = 1'b0;
    unload_strobe = 1'b0;
    data_in = 4'h0;
  end
  // 837 ns strobe period, phase unrelated to clk
  task automatic push(input logic [3:0] d, output logic ir);
    #37 data_in = d;
    #200 load_strobe = 1'b1;
    // a rank one part wide: the AND of its ready flags is this flag
    #450 ir = input_ready_flag;
    #50 load_strobe = 1'b0;
    // word no longer held: show something else
    #100 data_in = ~d;
  endtask : push
  task automatic pop(output logic rdy);
    #37 unload_strobe = 1'b1;
    #450 rdy = output_ready_flag;
    #50 unload_strobe = 1'b0;
    #300;
  endtask : pop
endmodule : dcf_peer

// ===== bench/dcf_fifo_tb.sv
// self-checking bench for the dcf fifo
`timescale 1ns/1ns
module dcf_fifo_tb;
  logic clk, sys_rst, load_strobe, unload_strobe, stack_clear_n;
  logic output_drive_en, data_out_oe, input_ready_flag, output_ready_flag;
  logic reg_wr, reg_rd, irq, ir, rdy;
  logic [dcf_pkg::WIDTH-1:0] data_in, data_out, w;
  logic [dcf_pkg::ADDR_W-1:0] reg_addr;
  logic [dcf_pkg::DATA_W-1:0] reg_wdata, reg_rdata, q;
  logic [dcf_pkg::WIDTH-1:0] exp_q[$];
  int error_cnt, checked, seed, cyc;

  dcf_fifo dcf_fifo_inst (.clk(clk), .sys_rst(sys_rst),
    .load_strobe(load_strobe), .data_in(data_in),
    .input_ready_flag(input_ready_flag), .unload_strobe(unload_strobe),
    .output_drive_en(output_drive_en), .data_out(data_out),
    .data_out_oe(data_out_oe), .output_ready_flag(output_ready_flag),
    .stack_clear_n(stack_clear_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  dcf_peer dcf_peer_inst (.load_strobe(load_strobe), .data_in(data_in),
    .input_ready_flag(input_ready_flag), .unload_strobe(unload_strobe),
    .output_ready_flag(output_ready_flag));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  function automatic logic [31:0] st(input int n, input logic en);
    st = 32'h0;
    st[4:0] = n[4:0];
    st[5] = (n == dcf_pkg::DEPTH);
    st[6] = (n == 0);
    st[7] = (n != dcf_pkg::DEPTH);
    st[10] = en;
  endfunction : st
  task automatic cst(input int n, input logic en);
    // ready flags lag a strobe's fall by the two sync stages plus the flag register
    repeat (2) @(posedge clk);
    rd(dcf_pkg::OFS_STATUS, q);
    chk("status", q, st(n, en));
  endtask : cst
  task automatic summarize();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 71065;
    sys_rst = 1'b1;
    stack_clear_n = 1'b1;
    output_drive_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    cst(0, 1'b1);
    rd(8'h10, q);
    chk("unmapped", q, 32'h0);
    wr(dcf_pkg::OFS_STATUS, 32'h3F);
    cst(0, 1'b1);
    wr(dcf_pkg::OFS_IRQ_MASK, 32'h3F);
    rd(dcf_pkg::OFS_IRQ_MASK, q);
    chk("mask", q, 32'h3F);
    wr(dcf_pkg::OFS_IRQ_STAT, 32'h3F);
    // one load past full to provoke overflow
    for (int i = 0; i < 17; i++) begin
      w = 4'($random(seed));
      dcf_peer_inst.push(w, ir);
      chk("in_ready", ir, 1'b0);
      // a single part: depth 15 m + 1 with m = 1
      if (i < 16) exp_q.push_back(w);
      cst(exp_q.size(), 1'b1);
    end
    rd(dcf_pkg::OFS_IRQ_STAT, q);
    chk("irq_stat", q, 32'h15);
    chk("irq", irq, 1'b1);
    wr(dcf_pkg::OFS_IRQ_STAT, 32'h3F);
    for (int i = 0; i < 17; i++) begin
      if (exp_q.size() > 0) chk("word", data_out, exp_q[0]);
      dcf_peer_inst.pop(rdy);
      chk("out_ready", rdy, exp_q.size() > 1);
      if (exp_q.size() > 0) w = exp_q.pop_front();
      cst(exp_q.size(), 1'b1);
    end
    rd(dcf_pkg::OFS_IRQ_STAT, q);
    chk("irq_stat", q, 32'h0A);
    wr(dcf_pkg::OFS_IRQ_STAT, 32'h3F);
    @(posedge clk);
    #1 chk("irq", irq, 1'b0);
    output_drive_en <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      dcf_peer_inst.push(4'($random(seed)), ir);
      chk("in_ready", ir, 1'b0);
    end
    chk("oe", data_out_oe, 1'b0);
    cst(3, 1'b0);
    @(posedge clk);
    stack_clear_n <= 1'b0;
    repeat (5) @(posedge clk);
    #1 chk("clr_ir", input_ready_flag, 1'b1);
    chk("clr_or", output_ready_flag, 1'b0);
    stack_clear_n <= 1'b1;
    output_drive_en <= 1'b1;
    repeat (4) @(posedge clk);
    cst(0, 1'b1);
    w = 4'($random(seed));
    wr(dcf_pkg::OFS_IRQ_MASK, 32'h0);
    dcf_peer_inst.push(w, ir);
    chk("first", data_out, w);
    chk("oe", data_out_oe, 1'b1);
    chk("irq", irq, 1'b0);
    // control-write clear empties the stack like the pin
    wr(dcf_pkg::OFS_CTRL, 32'h1);
    cst(0, 1'b1);
    rd(dcf_pkg::OFS_CTRL, q);
    chk("ctrl", q, 32'h0);
    summarize();
  end
endmodule : dcf_fifo_tb
